// [shared/spi_cfg_pkg.sv]
// Behaviour
// (R1) Stream direction bit set: each following streamed byte goes to next higher address.
// (R2) Stream direction bit clear (reset): each following streamed byte goes to next lower address.
// (R3) Bit order bit set: data shifted least significant bit first both ways.
// (R4) Bit order bit clear (reset): data shifted most significant bit first both ways.
// (R5) Writing one to the reinit bit starts an internal configuration reset.
// (R6) Reinit bit clears itself when the internal reset sequence finishes.
// (R7) Bits 7..4 are read-only mirrored copies of bits 0..3; writes ignored.
package spi_cfg_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] SERIAL_PORT_CONFIG_ADDR = 12'h000;
   localparam logic [7:0] SERIAL_PORT_CONFIG_RESET = 8'h00;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int REINIT_BIT = 0;
   localparam int BIT_ORDER_BIT = 1;
   localparam int STREAM_DIR_BIT = 2;
   localparam int OUT_PIN_BIT = 3;
   // ----------------------------------------
   // Reinit sequence length in clk cycles
   // ----------------------------------------
   localparam int REINIT_NS = 80;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [3:0] REINIT_CYCLES = 4'((REINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// [logic/reinit_seq.sv]
`timescale 1ns/100ps
module reinit_seq (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic start_in,
   output logic busy_out,
   output logic done_out
);
   import spi_cfg_pkg::*;
   logic [3:0] cnt_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 4'h0;
      end else if (start_in && cnt_q == 4'h0) begin
         cnt_q <= REINIT_CYCLES;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign busy_out = (cnt_q != 4'h0);
   assign done_out = (cnt_q == 4'h1);
endmodule

// [logic/serial_port_interface_config.sv]
`timescale 1ns/100ps
module serial_port_interface_config (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register access from the serial port engine
   input wire logic [11:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Streaming address stepping
   input wire logic stream_step_in,
   input wire logic [11:0] stream_addr_in,
   output logic [11:0] stream_next_addr_out,
   // Settings to the shifter and device
   output logic bit_order_reverse_out,
   output logic output_pin_activation_out,
   output logic cfg_reset_out
);
   import spi_cfg_pkg::*;

   // ----------------------------------------
   // Configuration bits
   // ----------------------------------------
   logic stream_addr_direction_q;
   logic bit_order_reverse_q;
   logic output_pin_activation_q;
   logic self_clearing_reinit_q;
   logic busy;
   logic done;
   logic cfg_wr;
   logic [7:0] low_bits;
   assign cfg_wr = reg_wr_in && (reg_addr_in == SERIAL_PORT_CONFIG_ADDR);

   // Settings survive the reinit, which resets the rest of the device config
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stream_addr_direction_q <= SERIAL_PORT_CONFIG_RESET[STREAM_DIR_BIT];
         bit_order_reverse_q <= SERIAL_PORT_CONFIG_RESET[BIT_ORDER_BIT];
         output_pin_activation_q <= SERIAL_PORT_CONFIG_RESET[OUT_PIN_BIT];
      end else if (cfg_wr) begin
         stream_addr_direction_q <= reg_wdata_in[STREAM_DIR_BIT];
         bit_order_reverse_q <= reg_wdata_in[BIT_ORDER_BIT]; // R3 R4
         output_pin_activation_q <= reg_wdata_in[OUT_PIN_BIT];
      end
   end

   // Self-clear wins over a set: a set is ignored while the reinit sequence is busy
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         self_clearing_reinit_q <= 1'b0;
      end else if (cfg_wr && reg_wdata_in[REINIT_BIT] && !busy) begin
         self_clearing_reinit_q <= 1'b1; // R5
      end else if (done) begin
         self_clearing_reinit_q <= 1'b0; // R6
      end
   end

   reinit_seq u_reinit (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(self_clearing_reinit_q),
      .busy_out(busy),
      .done_out(done)
   );
   assign cfg_reset_out = busy; // R5

   // ----------------------------------------
   // Readback with mirrored copies
   // ----------------------------------------
   assign low_bits = {4'h0, output_pin_activation_q, stream_addr_direction_q,
                      bit_order_reverse_q, self_clearing_reinit_q};
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         if (reg_addr_in == SERIAL_PORT_CONFIG_ADDR) begin
            reg_rdata_out <= {low_bits[0], low_bits[1], low_bits[2], low_bits[3], low_bits[3:0]}; // R7
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // Streaming address step
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stream_next_addr_out <= 12'h000;
      end else if (stream_step_in) begin
         if (stream_addr_direction_q) begin
            stream_next_addr_out <= stream_addr_in + 12'h001; // R1
         end else begin
            stream_next_addr_out <= stream_addr_in - 12'h001; // R2
         end
      end
   end

   assign bit_order_reverse_out = bit_order_reverse_q; // R3 R4
   assign output_pin_activation_out = output_pin_activation_q;
endmodule

// [dv/cfg_sva.sv]
`timescale 1ns/100ps
module cfg_sva(input wire logic clk_in,rst_n_in,reg_wr_in,reg_rd_in,stream_step_in,bit_order_reverse_out,
input wire logic cfg_reset_out,input wire logic [11:0] reg_addr_in,stream_addr_in,stream_next_addr_out,
input wire logic [7:0] reg_wdata_in,reg_rdata_out);
logic dir_q;
wire w0=reg_wr_in&&reg_addr_in==12'h000;
always_ff @(posedge clk_in or negedge rst_n_in) if (!rst_n_in) dir_q<=1'b0; else if (w0) dir_q<=reg_wdata_in[2];
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
sequence busy_run; cfg_reset_out[*8] ##1 !cfg_reset_out; endsequence
step_up_a: assert property (stream_step_in&&dir_q|=>stream_next_addr_out==$past(stream_addr_in)+12'h001) else $error("up");
step_down_a: assert property (stream_step_in&&!dir_q|=>stream_next_addr_out==$past(stream_addr_in)-12'h001) else $error("dn");
lsb_first_a: assert property (w0&&reg_wdata_in[1]|=>bit_order_reverse_out) else $error("lsb");
msb_first_a: assert property (w0&&!reg_wdata_in[1]|=>!bit_order_reverse_out) else $error("msb");
reinit_start_a: assert property (w0&&reg_wdata_in[0]&&!cfg_reset_out|=>##1 cfg_reset_out) else $error("start");
reinit_clear_a: assert property ($rose(cfg_reset_out)|->busy_run) else $error("clear");
mirror_bits_a: assert property (reg_rd_in&&reg_addr_in==12'h000|=>reg_rdata_out[7:4]==
   {reg_rdata_out[0],reg_rdata_out[1],reg_rdata_out[2],reg_rdata_out[3]}) else $error("mirror");
endmodule
bind serial_port_interface_config cfg_sva u_cfg_sva(.*);

// [dv/host_model.sv]
`timescale 1ns/100ps
module host_model(input wire logic clk_in,input wire logic [7:0] reg_rdata_out,
input wire logic [11:0] stream_next_addr_out,output logic [11:0] reg_addr_in,stream_addr_in,
output logic [7:0] reg_wdata_in,output logic reg_wr_in,reg_rd_in,stream_step_in);
initial {reg_addr_in,stream_addr_in,reg_wdata_in,reg_wr_in,reg_rd_in,stream_step_in}='0;
// Kind 0 write, 1 read, 2 stream step; one cycle each
task op(input logic [1:0] k,input logic [11:0] a,input logic [7:0] d,output logic [11:0] q);
   @(negedge clk_in) {reg_wr_in,reg_rd_in,stream_step_in}={k==0,k==1,k==2};
   {reg_addr_in,stream_addr_in,reg_wdata_in}={a,a,d};
   @(negedge clk_in) {reg_wr_in,reg_rd_in,stream_step_in}=3'h0;
   q=(k==2)?stream_next_addr_out:{4'h0,reg_rdata_out};
endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
logic clk_in=0,rst_n_in=0,reg_wr_in,reg_rd_in,stream_step_in,bit_order_reverse_out,output_pin_activation_out;
logic cfg_reset_out;
logic [11:0] reg_addr_in,stream_addr_in,stream_next_addr_out,q;
logic [7:0] reg_wdata_in,reg_rdata_out;
int n_fail=0,tests_run=0;
serial_port_interface_config u_serial_port_interface_config(.*);
host_model u_host_model(.*);
initial forever #5 clk_in=~clk_in;
task chk(input logic [11:0] g,e);
   tests_run++;
   if (g!==e) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h",$time,g,e);
   end
endtask
task t(input logic [1:0] k,input logic [11:0] a,input logic [7:0] d,input logic [11:0] e);
   u_host_model.op(k,a,d,q);
   if (k!=0) chk(q,e);
endtask
task print_verdict;
   if (n_fail==0&&tests_run>0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
initial begin
   #5000 n_fail++;
   print_verdict;
end
initial begin
   repeat(3) @(negedge clk_in);
   rst_n_in=1;
   t(1,0,0,12'h000);
   t(0,0,8'h06,0);
   chk(bit_order_reverse_out,1);
   t(1,0,0,12'h066);
   t(2,12'hFFF,0,12'h000);
   t(0,0,8'h00,0);
   chk(bit_order_reverse_out,0);
   t(2,12'h000,0,12'hFFF);
   t(0,0,8'hF9,0);
   repeat(2) @(negedge clk_in);
   chk(cfg_reset_out,1);
   t(1,0,0,12'h099);
   repeat(10) @(negedge clk_in);
   chk(cfg_reset_out,0);
   t(0,12'h001,8'hFF,0);
   t(1,12'h001,0,12'h000);
   t(1,0,0,12'h018);
   chk(output_pin_activation_out,1);
   print_verdict;
end
endmodule
